// [src/iqc_map.svh]
// register offsets, field positions, reset values and vector codes of the queue command block
`ifndef IQC_MAP_SVH
`define IQC_MAP_SVH
`define IQC_OFF_CMD 4'h0
`define IQC_OFF_STS 4'h4
`define IQC_OFF_CLR 4'h8
`define IQC_OFF_ENA 4'hc
`define IQC_CMD_RST 32'h0000_0200
`define IQC_CMD_WMASK 32'hff30_0200
`define IQC_BIT_AR 0
`define IQC_BIT_MASK 9
`define IQC_POLL_LO 10
`define IQC_RX_LO 28
`define IQC_TX_LO 24
`define IQC_BIT_CFGQ 21
`define IQC_BIT_PERQ 20
`define IQC_STS_ACK 0
`define IQC_STS_FAIL 1
`define IQC_STS_PERQ 18
`define IQC_QCFG 4'd8
`define IQC_QPER 4'd9
`define IQC_NQ 4'd10
`define IQC_VEC_ACK 32'h0000_00a1
`define IQC_VEC_FAIL 32'h0000_00af
`endif

// [src/iqc_pkg.sv]
// types shared by the queue command block
package iqc_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_SCAN, ST_FETCH, ST_REPORT, ST_PUSH} iqc_state_t;
  typedef logic [3:0] iqc_qidx_t;
endpackage

// [src/iqc_queue_cfg.sv]
// global command register, queue configuration engine and vector writer
//
// Behaviour
// RULE_01 - command bits 31..28 select receive queues of channels 3..0 for configuration
// RULE_02 - command bits 27..24 select transmit queues of channels 3..0 for configuration
// RULE_03 - receive vectors go into their channel queue once that queue is configured
// RULE_04 - bit 21 selects the configuration queue, which takes acknowledge and fail vectors
// RULE_05 - selection acts only on an action request; unselected queues keep their setup
// RULE_06 - each selected queue has base and length fetched and applied on the request
// RULE_07 - software loads base and length before issuing the action request
// RULE_08 - action request bit clears itself; after all fetches, acknowledge or fail is flagged
// RULE_09 - mask bit resets to one; while one, no acknowledge or fail vector is written
// RULE_10 - transmit poll bits self-clear and act only on a held channel
// RULE_11 - bit 20 selects the peripheral queue fed by the local bus interface
// RULE_12 - unused command bits read zero and ignore writes
//
// Added by the designer: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "iqc_map.svh"
module iqc_queue_cfg
#(
  parameter int LEN_W = 16
)
(
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_ce,
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output logic o_irq,
  output logic o_rd_req,
  output iqc_pkg::iqc_qidx_t o_rd_qidx,
  input wire logic i_rd_ack,
  input wire logic i_rd_err,
  input wire logic [31:0] i_rd_base,
  input wire logic [LEN_W-1:0] i_rd_len,
  input wire logic i_vec_valid,
  input wire iqc_pkg::iqc_qidx_t i_vec_qidx,
  input wire logic [31:0] i_vec_data,
  output logic o_vec_ready,
  output logic o_mem_wr,
  output logic [31:0] o_mem_addr,
  output logic [31:0] o_mem_data,
  input wire logic [3:0] i_tx_held,
  output logic [3:0] o_tx_poll
);
  import iqc_pkg::*;

  logic [31:0] cmd_r;
  logic [31:0] sts_r;
  logic [31:0] ena_r;
  logic [31:0] sts_set_r;
  logic wait_r;
  logic [31:0] rdata_r;
  logic ar_go_r;
  logic [9:0] ar_sel_r;
  logic [3:0] poll_r;
  logic irq_r;
  iqc_state_t st_r;
  logic [9:0] sel_r;
  iqc_qidx_t qi_r;
  logic fail_r;
  logic rd_req_r;
  logic vec_rdy_r;
  iqc_qidx_t push_q_r;
  logic [31:0] push_d_r;
  logic mem_wr_r;
  logic [31:0] mem_addr_r;
  logic [31:0] mem_data_r;
  logic [9:0] q_ok_r;
  logic [31:0] q_base_r [10];
  logic [LEN_W-1:0] q_len_r [10];
  logic [LEN_W-1:0] q_ptr_r [10];
  logic acc;
  logic busy;

  // queue index order: rx ch0..3, tx ch0..3, config, peripheral
  function automatic logic [9:0] sel_of(input logic [31:0] w);
    sel_of = {w[`IQC_BIT_PERQ], w[`IQC_BIT_CFGQ], w[`IQC_TX_LO +: 4], w[`IQC_RX_LO +: 4]};
  endfunction

  // status bit that reports a vector written into queue q
  function automatic logic [31:0] sts_bit(input iqc_qidx_t q);
    logic [31:0] m;
    m = 32'h0;
    if (q < 4'd4)
    begin
      m[`IQC_RX_LO + 32'(q)] = 1'b1;
    end
    else if (q < `IQC_QCFG)
    begin
      m[`IQC_TX_LO + 32'(q) - 4] = 1'b1;
    end
    else if (q == `IQC_QCFG)
    begin
      m[`IQC_BIT_CFGQ] = 1'b1;
    end
    else
    begin
      m[`IQC_STS_PERQ] = 1'b1;
    end
    sts_bit = m;
  endfunction

  assign acc = (i_avs_read || i_avs_write) && !wait_r;
  assign busy = (st_r != ST_IDLE) || ar_go_r;

  // one wait cycle per access; read data loads on the edge that drops waitrequest, write data lands on the edge that sees it low
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      wait_r <= 1'b1;
      rdata_r <= 32'h0;
    end
    else if (i_ce)
    begin
      if (acc)
      begin
        wait_r <= 1'b1;
      end
      else if (i_avs_read || i_avs_write)
      begin
        wait_r <= 1'b0;
        rdata_r <= 32'h0;
        if (i_avs_read)
        begin
          unique case (i_avs_address)
            `IQC_OFF_CMD: rdata_r <= (cmd_r & `IQC_CMD_WMASK) | {31'h0, busy}; // RULE_12
            `IQC_OFF_STS: rdata_r <= sts_r;
            `IQC_OFF_ENA: rdata_r <= ena_r;
            default: rdata_r <= 32'h0;
          endcase
        end
      end
    end
  end

  // command register; action request and poll bits are never stored
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      cmd_r <= `IQC_CMD_RST; // RULE_09
      ena_r <= 32'h0;
      ar_go_r <= 1'b0;
      ar_sel_r <= 10'h0;
      poll_r <= 4'h0;
    end
    else if (i_ce)
    begin
      ar_go_r <= 1'b0;
      poll_r <= 4'h0;
      if (acc && i_avs_write && i_avs_address == `IQC_OFF_CMD)
      begin
        cmd_r <= i_avs_writedata & `IQC_CMD_WMASK; // RULE_12
        // poll only counts while the channel sits on a held descriptor
        poll_r <= i_avs_writedata[`IQC_POLL_LO +: 4] & i_tx_held; // RULE_10
        // a request during a running one is dropped; the running one still reports
        if (i_avs_writedata[`IQC_BIT_AR] && !busy)
        begin
          ar_go_r <= 1'b1; // RULE_08
          ar_sel_r <= sel_of(i_avs_writedata); // RULE_01 RULE_02 RULE_04 RULE_11
        end
      end
      if (acc && i_avs_write && i_avs_address == `IQC_OFF_ENA)
      begin
        ena_r <= i_avs_writedata;
      end
    end
  end

  // sticky status; a new event beats a clear in the same cycle
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      sts_r <= 32'h0;
      irq_r <= 1'b0;
    end
    else if (i_ce)
    begin
      if (acc && i_avs_write && i_avs_address == `IQC_OFF_CLR)
      begin
        sts_r <= (sts_r & ~i_avs_writedata) | sts_set_r;
      end
      else
      begin
        sts_r <= sts_r | sts_set_r;
      end
      irq_r <= |(sts_r & ena_r);
    end
  end

  // configuration engine and vector writer share one sequencer, so queue state has one owner
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      st_r <= ST_IDLE;
      sel_r <= 10'h0;
      qi_r <= 4'h0;
      fail_r <= 1'b0;
      rd_req_r <= 1'b0;
      vec_rdy_r <= 1'b0;
      push_q_r <= 4'h0;
      push_d_r <= 32'h0;
      mem_wr_r <= 1'b0;
      mem_addr_r <= 32'h0;
      mem_data_r <= 32'h0;
      sts_set_r <= 32'h0;
      q_ok_r <= 10'h0;
      for (int i = 0; i < 10; i++)
      begin
        q_base_r[i] <= 32'h0;
        q_len_r[i] <= '0;
        q_ptr_r[i] <= '0;
      end
    end
    else if (i_ce)
    begin
      vec_rdy_r <= 1'b0;
      mem_wr_r <= 1'b0;
      sts_set_r <= 32'h0;
      unique case (st_r)
        ST_IDLE:
        begin
          if (ar_go_r)
          begin
            sel_r <= ar_sel_r; // RULE_05
            qi_r <= 4'h0;
            fail_r <= 1'b0;
            st_r <= ST_SCAN;
          end
          else if (i_vec_valid)
          begin
            vec_rdy_r <= 1'b1;
            push_q_r <= i_vec_qidx;
            push_d_r <= i_vec_data;
            st_r <= ST_PUSH;
          end
        end
        ST_SCAN:
        begin
          if (qi_r == `IQC_NQ)
          begin
            st_r <= ST_REPORT;
          end
          else if (sel_r[qi_r])
          begin
            rd_req_r <= 1'b1; // RULE_06
            st_r <= ST_FETCH;
          end
          else
          begin
            qi_r <= qi_r + 4'd1; // RULE_05
          end
        end
        ST_FETCH:
        begin
          if (i_rd_ack)
          begin
            rd_req_r <= 1'b0;
            // base and length must already be loaded; zero length is a failed setup
            if (i_rd_err || i_rd_len == '0) // RULE_07
            begin
              fail_r <= 1'b1;
            end
            else
            begin
              q_base_r[qi_r] <= i_rd_base; // RULE_06
              q_len_r[qi_r] <= i_rd_len;
              q_ptr_r[qi_r] <= '0;
              q_ok_r[qi_r] <= 1'b1;
            end
            qi_r <= qi_r + 4'd1;
            st_r <= ST_SCAN;
          end
        end
        ST_REPORT:
        begin
          sts_set_r[fail_r ? `IQC_STS_FAIL : `IQC_STS_ACK] <= 1'b1; // RULE_08
          push_q_r <= `IQC_QCFG; // RULE_04
          push_d_r <= fail_r ? `IQC_VEC_FAIL : `IQC_VEC_ACK;
          st_r <= cmd_r[`IQC_BIT_MASK] ? ST_IDLE : ST_PUSH; // RULE_09
        end
        ST_PUSH:
        begin
          // vectors for a queue that was never set up are dropped
          if (push_q_r < `IQC_NQ && q_ok_r[push_q_r]) // RULE_03 RULE_11
          begin
            mem_wr_r <= 1'b1;
            mem_addr_r <= q_base_r[push_q_r] + {{(30-LEN_W){1'b0}}, q_ptr_r[push_q_r], 2'b00};
            mem_data_r <= push_d_r;
            q_ptr_r[push_q_r] <= (q_ptr_r[push_q_r] + 1'b1 == q_len_r[push_q_r]) ?
              '0 : q_ptr_r[push_q_r] + 1'b1;
            sts_set_r <= sts_bit(push_q_r);
          end
          st_r <= ST_IDLE;
        end
      endcase
    end
  end

  assign o_avs_readdata = rdata_r;
  assign o_avs_waitrequest = wait_r;
  assign o_irq = irq_r;
  assign o_rd_req = rd_req_r;
  assign o_rd_qidx = qi_r;
  assign o_vec_ready = vec_rdy_r;
  assign o_mem_wr = mem_wr_r;
  assign o_mem_addr = mem_addr_r;
  assign o_mem_data = mem_data_r;
  assign o_tx_poll = poll_r;
endmodule

// [tb/iqc_fetch_model.sv]
// stand-in for the queue base and length registers answering fetches
`timescale 1ns/1ps
module iqc_fetch_model
(
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_req,
  input wire iqc_pkg::iqc_qidx_t i_qidx,
  input wire logic [3:0] i_bad_q,
  input wire logic [3:0] i_dly,
  output logic o_ack,
  output logic [31:0] o_base,
  output logic [15:0] o_len
);
  import iqc_pkg::*;
  logic [3:0] cnt_r;
  // base and length are scrambled outside the answer so a late sample shows up
  always_ff @(posedge i_mclk or negedge i_nrst)
    if (!i_nrst)
    begin
      cnt_r <= 4'h0;
      o_ack <= 1'b0;
      o_base <= 32'h0;
      o_len <= 16'h0;
    end
    else if (i_req && !o_ack && cnt_r >= i_dly)
    begin
      cnt_r <= 4'h0;
      o_ack <= 1'b1;
      o_base <= {4'h0, i_qidx, 24'h0};
      o_len <= (i_qidx == i_bad_q) ? 16'h0 : 16'h8;
    end
    else
    begin
      cnt_r <= i_req ? cnt_r + 4'h1 : 4'h0;
      o_ack <= 1'b0;
      o_base <= ~o_base;
      o_len <= ~o_len;
    end
endmodule

// [tb/iqc_queue_cfg_properties.sv]
// port-level checks of the queue command block
`timescale 1ns/1ps
`include "iqc_map.svh"
module iqc_queue_cfg_properties
(
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic o_avs_waitrequest,
  input wire logic o_rd_req,
  input wire iqc_pkg::iqc_qidx_t o_rd_qidx,
  input wire logic i_rd_ack,
  input wire logic i_vec_valid,
  input wire logic [31:0] i_vec_data,
  input wire logic o_vec_ready,
  input wire logic o_mem_wr,
  input wire logic [31:0] o_mem_data,
  input wire logic [3:0] i_tx_held,
  input wire logic [3:0] o_tx_poll
);
  import iqc_pkg::*;
  logic wr_cmd;
  assign wr_cmd = i_avs_write && !o_avs_waitrequest && i_avs_address == 4'h0;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  sequence s_ask;
    (i_avs_read || i_avs_write) && o_avs_waitrequest;
  endsequence
  property p_wait;
    s_ask |=> !o_avs_waitrequest;
  endproperty
  a_wait: assert property (p_wait) else $error("bus request not answered next cycle");
  property p_poll;
    wr_cmd && (i_avs_writedata[13:10] & i_tx_held) != 4'h0 |-> ##[1:2] o_tx_poll != 4'h0;
  endproperty
  a_poll: assert property (p_poll) else $error("poll of held channel lost");
  property p_nopoll;
    o_tx_poll != 4'h0 |-> $past(wr_cmd) || $past(wr_cmd, 2);
  endproperty
  a_nopoll: assert property (p_nopoll) else $error("poll without command write");
  property p_rdhold;
    o_rd_req && !i_rd_ack |=> o_rd_req && $stable(o_rd_qidx);
  endproperty
  a_rdhold: assert property (p_rdhold) else $error("fetch request dropped early");
  property p_rdidx;
    o_rd_req |-> o_rd_qidx <= `IQC_QPER;
  endproperty
  a_rdidx: assert property (p_rdidx) else $error("fetch of unknown queue");
  property p_vec;
    o_vec_ready |-> $past(i_vec_valid);
  endproperty
  a_vec: assert property (p_vec) else $error("vector taken while none offered");
  property p_data;
    o_mem_wr && $past(o_vec_ready) |-> o_mem_data == $past(i_vec_data, 2);
  endproperty
  a_data: assert property (p_data) else $error("vector data corrupted");
  property p_arvec;
    o_mem_wr && !$past(o_vec_ready) |-> o_mem_data inside {`IQC_VEC_ACK, `IQC_VEC_FAIL};
  endproperty
  a_arvec: assert property (p_arvec) else $error("bad report vector");
endmodule

// [tb/tb_iqc_queue_cfg.sv]
// self-checking bench of the queue command block
`timescale 1ns/1ps
`include "iqc_map.svh"
module tb_iqc_queue_cfg;
  import iqc_pkg::*;
  logic i_mclk = 1'b0, i_nrst = 1'b0, i_avs_read = 1'b0, i_avs_write = 1'b0, i_vec_valid = 1'b0;
  logic [3:0] i_avs_address = 4'h0, i_tx_held = 4'h5, dly = 4'h0, bad = 4'hf, pseen = 4'h0;
  logic [31:0] i_avs_writedata = 32'h0, i_vec_data = 32'h0, rdt, m_addr, m_data, nf = 32'h0;
  logic o_avs_waitrequest, o_irq, o_rd_req, i_rd_ack, o_vec_ready, o_mem_wr;
  logic [31:0] o_avs_readdata, i_rd_base, o_mem_addr, o_mem_data;
  logic [15:0] i_rd_len;
  logic rerr = 1'b0;
  logic [3:0] o_tx_poll;
  iqc_qidx_t o_rd_qidx, i_vec_qidx = 4'h0;
  int n_errors = 0, cmp_count = 0, cyc = 0;
  iqc_queue_cfg DUT (.i_mclk, .i_nrst, .i_ce(1'b1), .i_avs_address, .i_avs_read, .i_avs_write,
    .i_avs_writedata, .o_avs_readdata, .o_avs_waitrequest, .o_irq, .o_rd_req, .o_rd_qidx,
    .i_rd_ack, .i_rd_err(rerr), .i_rd_base, .i_rd_len, .i_vec_valid, .i_vec_qidx, .i_vec_data,
    .o_vec_ready, .o_mem_wr, .o_mem_addr, .o_mem_data, .i_tx_held, .o_tx_poll);
  iqc_fetch_model u_fetch (.i_mclk, .i_nrst, .i_req(o_rd_req), .i_qidx(o_rd_qidx),
    .i_bad_q(bad), .i_dly(dly), .o_ack(i_rd_ack), .o_base(i_rd_base), .o_len(i_rd_len));
  always #10 i_mclk = ~i_mclk;
  always @(posedge i_mclk)
  begin
    pseen <= pseen | o_tx_poll;
    if (i_rd_ack === 1'b1)
      nf <= nf + 32'h1;
    if (o_mem_wr === 1'b1)
    begin
      m_addr <= o_mem_addr;
      m_data <= o_mem_data;
    end
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_errors++;
      test_done();
    end
  end
  task automatic test_done();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
    end
  endtask
  // one idle edge before each request keeps strobes from being driven twice at one edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    i_avs_address <= a;
    i_avs_writedata <= d;
    i_avs_write <= w;
    i_avs_read <= !w;
    do @(posedge i_mclk); while (o_avs_waitrequest !== 1'b0);
    rdt = o_avs_readdata;
    i_avs_write <= 1'b0;
    i_avs_read <= 1'b0;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [31:0] e, input string s);
    bus(1'b0, a, 32'h0);
    chk(s, e, rdt);
  endtask
  task automatic idle();
    repeat (40)
    begin
      bus(1'b0, 4'h0, 32'h0);
      if (rdt[0] === 1'b0)
        break;
    end
  endtask
  task automatic vec(input iqc_qidx_t q, input logic [31:0] d);
    @(posedge i_mclk);
    i_vec_valid <= 1'b1;
    i_vec_qidx <= q;
    i_vec_data <= d;
    do @(posedge i_mclk); while (o_vec_ready !== 1'b1);
    i_vec_valid <= 1'b0;
    repeat (3) @(posedge i_mclk);
  endtask
  initial
  begin
    repeat (20) @(posedge i_mclk);
    i_nrst <= 1'b1;
    rchk(4'h0, `IQC_CMD_RST, "cmd reset");
    bus(1'b1, 4'h0, 32'hffff_fffe);
    rchk(4'h0, 32'hff30_0200, "cmd readback");
    chk("fetch without request", 32'h0, nf);
    chk("poll", 32'h5, 32'(pseen));
    bus(1'b1, 4'h2, 32'hffff_ffff);
    rchk(4'h2, 32'h0, "unmapped");
    bus(1'b1, 4'hc, 32'hffff_ffff);
    bus(1'b1, 4'h0, 32'h1020_0001);
    idle();
    rchk(4'h4, 32'h0020_0001, "ack status");
    chk("fetches", 32'h2, nf);
    chk("ack vector", `IQC_VEC_ACK, m_data);
    chk("cfg queue addr", 32'h0800_0000, m_addr);
    chk("irq set", 32'h1, 32'(o_irq));
    bus(1'b1, 4'h8, 32'hffff_ffff);
    rchk(4'h4, 32'h0, "cleared");
    chk("irq clear", 32'h0, 32'(o_irq));
    vec(4'h0, 32'h11);
    vec(4'h0, 32'h22);
    chk("rx ptr addr", 32'h4, m_addr);
    vec(4'h1, 32'h33);
    chk("unconfigured drop", 32'h22, m_data);
    rchk(4'h4, 32'h1000_0000, "rx status");
    bus(1'b1, 4'hc, 32'h0);
    rchk(4'h4, 32'h1000_0000, "masked status");
    chk("irq masked", 32'h0, 32'(o_irq));
    bus(1'b1, 4'h8, 32'hffff_ffff);
    bad <= 4'h0;
    dly <= 4'h6;
    bus(1'b1, 4'h0, 32'h1000_0201);
    idle();
    rchk(4'h4, 32'h0000_0002, "fail status");
    chk("masked report", 32'h22, m_data);
    vec(4'h0, 32'h44);
    chk("old setup kept", 32'h8, m_addr);
    bad <= 4'hf;
    dly <= 4'h0;
    bus(1'b1, 4'h8, 32'hffff_ffff);
    bus(1'b1, 4'h0, 32'h0110_0001);
    idle();
    rchk(4'h4, 32'h0020_0001, "tx and peripheral ack");
    chk("fetch count", 32'h5, nf);
    chk("cfg queue next slot", 32'h0800_0004, m_addr);
    vec(4'h4, 32'h55);
    chk("tx queue addr", 32'h0400_0000, m_addr);
    vec(4'h9, 32'h66);
    chk("peripheral queue addr", 32'h0900_0000, m_addr);
    rchk(4'h4, 32'h0124_0001, "queue status");
    bus(1'b1, 4'h8, 32'hffff_ffff);
    // a fetch error must fail the request just like a zero length
    rerr <= 1'b1;
    bus(1'b1, 4'h0, 32'h0010_0001);
    idle();
    rerr <= 1'b0;
    rchk(4'h4, 32'h0020_0002, "fetch error status");
    chk("fail vector", `IQC_VEC_FAIL, m_data);
    vec(4'h9, 32'h77);
    chk("failed setup kept", 32'h0900_0004, m_addr);
    i_nrst <= 1'b0;
    repeat (2) @(posedge i_mclk);
    i_nrst <= 1'b1;
    rchk(4'h0, `IQC_CMD_RST, "cmd after reset");
    rchk(4'h4, 32'h0, "status after reset");
    vec(4'h0, 32'h88);
    chk("setup lost on reset", 32'h77, m_data);
    test_done();
  end
endmodule
bind iqc_queue_cfg iqc_queue_cfg_properties u_chk (.i_mclk, .i_nrst, .i_avs_address,
  .i_avs_read, .i_avs_write, .i_avs_writedata, .o_avs_waitrequest, .o_rd_req, .o_rd_qidx,
  .i_rd_ack, .i_vec_valid, .i_vec_data, .o_vec_ready, .o_mem_wr, .o_mem_data, .i_tx_held,
  .o_tx_poll);
